/* File: src/bclalu_pkg.sv */
// Package for the BCD and logic ALU: opcodes, carry address, request and result types.
// Assumes a single clock domain and a word-wide data memory port.
package bclalu_pkg;

   // ==========================================================
   // Opcodes and constants
   // ==========================================================
   typedef enum logic [2:0]
   {
      BCLALU_OP_ADD = 3'h0,
      BCLALU_OP_SUB = 3'h1,
      BCLALU_OP_AND = 3'h2,
      BCLALU_OP_OR = 3'h3,
      BCLALU_OP_CLC = 3'h4
   } bclalu_op_t;

   localparam logic [15:0] BCLALU_CARRY_BIT_ADDR = 16'h0312;
   localparam logic [7:0] BCLALU_CODE_ADD = 8'h40;
   localparam logic [7:0] BCLALU_CODE_SUB = 8'h41;
   localparam logic [7:0] BCLALU_CODE_AND = 8'h42;
   localparam logic [7:0] BCLALU_CODE_OR = 8'h43;
   localparam logic [7:0] BCLALU_CODE_CLC = 8'h44;
   localparam logic BCLALU_CARRY_RESET = 1'h0;
   localparam logic [15:0] BCLALU_RESULT_RESET = 16'h0000;
   localparam int BCLALU_DIGITS = 4;

   // ==========================================================
   // Carried groups
   // ==========================================================
   typedef struct packed
   {
      logic [7:0] code;
      logic ind_a;
      logic ind_b;
      logic ind_d;
      logic [15:0] addr_a;
      logic [15:0] addr_b;
      logic [15:0] addr_d;
   } bclalu_req_t;

   typedef struct packed
   {
      logic [15:0] word;
      logic carry;
   } bclalu_res_t;

endpackage : bclalu_pkg

/* File: src/bclalu_bcd.sv */
// Four-digit BCD adder/subtractor with carry or borrow in and out.
// Assumes operand digits are valid BCD; invalid digits give undefined sums.
`timescale 1ns/1ps
module bclalu_bcd #(
   parameter int DIGITS = 4
)
(
   input wire logic [4*DIGITS-1:0] a,
   input wire logic [4*DIGITS-1:0] b,
   input wire logic cin,
   input wire logic sub,
   output logic [4*DIGITS-1:0] sum,
   output logic cout
);

   logic [DIGITS:0] c;
   assign c[0] = cin;
   assign cout = c[DIGITS];

   // ==========================================================
   // Digit chain
   // ==========================================================
   genvar g;
   generate
      for (g = 0; g < DIGITS; g++)
      begin : g_dig
         logic [4:0] t;
         logic [3:0] da;
         logic [3:0] db;
         logic [3:0] s;
         logic co;
         assign da = a[4*g +: 4];
         assign db = b[4*g +: 4];
         assign c[g+1] = co;
         assign sum[4*g +: 4] = s;
         always_comb
         begin
            if (sub)
            begin
               t = {1'b0, da} - {1'b0, db} - {4'h0, c[g]};
               co = t[4];
               s = t[4] ? 4'(t[3:0] + 4'hA) : t[3:0];
            end
            else
            begin
               t = {1'b0, da} + {1'b0, db} + {4'h0, c[g]};
               co = (t > 5'h09);
               s = (t > 5'h09) ? 4'(t[3:0] + 4'h6) : t[3:0];
            end
         end
      end
   endgenerate

endmodule : bclalu_bcd

/* File: src/bclalu_core.sv */
// BCD and logic ALU: fetches two operands, computes, writes a result word.
// Assumes a data memory with one-cycle read latency and single-cycle write.
//
// Summary of operation
// - BCD add sums two words and carry; result word and decimal carry out.
// - BCD subtract takes second word and carry from first; borrow to carry.
// - Word AND combines operands bitwise; carry left unchanged.
// - Word OR combines operands bitwise into the result word.
// - Carry clear forces carry bit 0312 to zero, nothing else.
// - Operands are direct words or indirect through a data register.
`timescale 1ns/1ps
module bclalu_core #(
   parameter int DIGITS = bclalu_pkg::BCLALU_DIGITS
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic req_valid,
   input wire bclalu_pkg::bclalu_req_t req,
   output logic req_ready,
   output logic mem_rd_en,
   output logic [15:0] mem_rd_addr,
   input wire logic [15:0] mem_rd_data,
   output logic mem_wr_en,
   output logic [15:0] mem_wr_addr,
   output logic [15:0] mem_wr_data,
   output logic carry_flag,
   output logic done,
   output logic bad_code
);

   // ==========================================================
   // Types and decode
   // ==========================================================
   typedef enum logic [3:0]
   {
      BCLALU_S_IDLE = 4'h0,
      BCLALU_S_PTR_A = 4'h1,
      BCLALU_S_PTR_AW = 4'h2,
      BCLALU_S_RD_A = 4'h3,
      BCLALU_S_RD_AW = 4'h4,
      BCLALU_S_PTR_B = 4'h5,
      BCLALU_S_PTR_BW = 4'h6,
      BCLALU_S_RD_B = 4'h7,
      BCLALU_S_RD_BW = 4'h8,
      BCLALU_S_PTR_D = 4'h9,
      BCLALU_S_PTR_DW = 4'hA,
      BCLALU_S_EXEC = 4'hB
   } bclalu_state_t;

   function automatic bclalu_pkg::bclalu_op_t decode_op(input logic [7:0] c);
      case (c)
         bclalu_pkg::BCLALU_CODE_ADD: decode_op = bclalu_pkg::BCLALU_OP_ADD;
         bclalu_pkg::BCLALU_CODE_SUB: decode_op = bclalu_pkg::BCLALU_OP_SUB;
         bclalu_pkg::BCLALU_CODE_AND: decode_op = bclalu_pkg::BCLALU_OP_AND;
         bclalu_pkg::BCLALU_CODE_OR: decode_op = bclalu_pkg::BCLALU_OP_OR;
         default: decode_op = bclalu_pkg::BCLALU_OP_CLC;
      endcase
   endfunction : decode_op

   function automatic logic known_code(input logic [7:0] c);
      known_code = (c >= bclalu_pkg::BCLALU_CODE_ADD) &&
                   (c <= bclalu_pkg::BCLALU_CODE_CLC);
   endfunction : known_code

   // ==========================================================
   // State
   // ==========================================================
   bclalu_state_t st_r, st_nxt;
   bclalu_pkg::bclalu_req_t req_r, req_nxt;
   logic [15:0] opa_r, opa_nxt;
   logic [15:0] opb_r, opb_nxt;
   logic [15:0] dst_r, dst_nxt;
   logic carry_r, carry_nxt;
   logic rd_en_r, rd_en_nxt;
   logic [15:0] rd_addr_r, rd_addr_nxt;
   logic wr_en_r, wr_en_nxt;
   logic [15:0] wr_addr_r, wr_addr_nxt;
   logic [15:0] wr_data_r, wr_data_nxt;
   logic done_r, done_nxt;
   logic bad_r, bad_nxt;
   logic ready_r, ready_nxt;

   bclalu_pkg::bclalu_res_t bcd_res;
   bclalu_pkg::bclalu_op_t op;
   assign op = decode_op(req_r.code);

   bclalu_bcd #(.DIGITS(DIGITS)) u_bcd (
      .a(opa_r),
      .b(opb_r),
      .cin(carry_r),
      .sub(op == bclalu_pkg::BCLALU_OP_SUB),
      .sum(bcd_res.word),
      .cout(bcd_res.carry)
   );

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb
   begin
      st_nxt = st_r;
      req_nxt = req_r;
      opa_nxt = opa_r;
      opb_nxt = opb_r;
      dst_nxt = dst_r;
      carry_nxt = carry_r;
      rd_en_nxt = 1'b0;
      rd_addr_nxt = rd_addr_r;
      wr_en_nxt = 1'b0;
      wr_addr_nxt = wr_addr_r;
      wr_data_nxt = wr_data_r;
      done_nxt = 1'b0;
      bad_nxt = 1'b0;
      ready_nxt = 1'b0;
      case (st_r)
         BCLALU_S_IDLE:
         begin
            ready_nxt = 1'b1;
            if (req_valid && ready_r)
            begin
               ready_nxt = 1'b0;
               req_nxt = req;
               dst_nxt = req.addr_d;
               if (!known_code(req.code))
               begin
                  bad_nxt = 1'b1;
                  done_nxt = 1'b1;
                  ready_nxt = 1'b1;
               end
               else if (decode_op(req.code) == bclalu_pkg::BCLALU_OP_CLC)
               begin
                  carry_nxt = 1'b0;
                  done_nxt = 1'b1;
                  ready_nxt = 1'b1;
               end
               else
               begin
                  rd_en_nxt = 1'b1;
                  rd_addr_nxt = req.addr_a;
                  st_nxt = req.ind_a ? BCLALU_S_PTR_A : BCLALU_S_RD_A;
               end
            end
         end
         BCLALU_S_PTR_A: st_nxt = BCLALU_S_PTR_AW;
         BCLALU_S_PTR_AW:
         begin
            rd_en_nxt = 1'b1;
            rd_addr_nxt = mem_rd_data;
            st_nxt = BCLALU_S_RD_A;
         end
         BCLALU_S_RD_A: st_nxt = BCLALU_S_RD_AW;
         BCLALU_S_RD_AW:
         begin
            opa_nxt = mem_rd_data;
            rd_en_nxt = 1'b1;
            rd_addr_nxt = req_r.addr_b;
            st_nxt = req_r.ind_b ? BCLALU_S_PTR_B : BCLALU_S_RD_B;
         end
         BCLALU_S_PTR_B: st_nxt = BCLALU_S_PTR_BW;
         BCLALU_S_PTR_BW:
         begin
            rd_en_nxt = 1'b1;
            rd_addr_nxt = mem_rd_data;
            st_nxt = BCLALU_S_RD_B;
         end
         BCLALU_S_RD_B: st_nxt = BCLALU_S_RD_BW;
         BCLALU_S_RD_BW:
         begin
            opb_nxt = mem_rd_data;
            if (req_r.ind_d)
            begin
               rd_en_nxt = 1'b1;
               rd_addr_nxt = req_r.addr_d;
               st_nxt = BCLALU_S_PTR_D;
            end
            else
            begin
               st_nxt = BCLALU_S_EXEC;
            end
         end
         BCLALU_S_PTR_D: st_nxt = BCLALU_S_PTR_DW;
         BCLALU_S_PTR_DW:
         begin
            dst_nxt = mem_rd_data;
            st_nxt = BCLALU_S_EXEC;
         end
         BCLALU_S_EXEC:
         begin
            wr_en_nxt = 1'b1;
            wr_addr_nxt = dst_r;
            done_nxt = 1'b1;
            ready_nxt = 1'b1;
            st_nxt = BCLALU_S_IDLE;
            case (op)
               bclalu_pkg::BCLALU_OP_ADD,
               bclalu_pkg::BCLALU_OP_SUB:
               begin
                  wr_data_nxt = bcd_res.word;
                  carry_nxt = bcd_res.carry;
               end
               bclalu_pkg::BCLALU_OP_AND:
               begin
                  wr_data_nxt = opa_r & opb_r;
               end
               bclalu_pkg::BCLALU_OP_OR:
               begin
                  wr_data_nxt = opa_r | opb_r;
               end
               default:
               begin
                  wr_en_nxt = 1'b0;
               end
            endcase
         end
         default: st_nxt = BCLALU_S_IDLE;
      endcase
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         st_r <= BCLALU_S_IDLE;
         req_r <= '0;
         opa_r <= bclalu_pkg::BCLALU_RESULT_RESET;
         opb_r <= bclalu_pkg::BCLALU_RESULT_RESET;
         dst_r <= bclalu_pkg::BCLALU_RESULT_RESET;
         carry_r <= bclalu_pkg::BCLALU_CARRY_RESET;
         rd_en_r <= 1'b0;
         rd_addr_r <= 16'h0000;
         wr_en_r <= 1'b0;
         wr_addr_r <= 16'h0000;
         wr_data_r <= bclalu_pkg::BCLALU_RESULT_RESET;
         done_r <= 1'b0;
         bad_r <= 1'b0;
         ready_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         req_r <= req_nxt;
         opa_r <= opa_nxt;
         opb_r <= opb_nxt;
         dst_r <= dst_nxt;
         carry_r <= carry_nxt;
         rd_en_r <= rd_en_nxt;
         rd_addr_r <= rd_addr_nxt;
         wr_en_r <= wr_en_nxt;
         wr_addr_r <= wr_addr_nxt;
         wr_data_r <= wr_data_nxt;
         done_r <= done_nxt;
         bad_r <= bad_nxt;
         ready_r <= ready_nxt;
      end
   end

   assign req_ready = ready_r;
   assign mem_rd_en = rd_en_r;
   assign mem_rd_addr = rd_addr_r;
   assign mem_wr_en = wr_en_r;
   assign mem_wr_addr = wr_addr_r;
   assign mem_wr_data = wr_data_r;
   assign carry_flag = carry_r;
   assign done = done_r;
   assign bad_code = bad_r;

endmodule : bclalu_core

/* File: dv/bclalu_core_asserts.sv */
// Port checker for the BCD and logic ALU core.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module bclalu_core_asserts #(
   parameter int DIGITS = 4
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic req_valid,
   input wire bclalu_pkg::bclalu_req_t req,
   input wire logic req_ready,
   input wire logic mem_rd_en,
   input wire logic [15:0] mem_rd_addr,
   input wire logic [15:0] mem_rd_data,
   input wire logic mem_wr_en,
   input wire logic [15:0] mem_wr_addr,
   input wire logic [15:0] mem_wr_data,
   input wire logic carry_flag,
   input wire logic done,
   input wire logic bad_code
);
   // ==========================================================
   // Helper terms
   // ==========================================================
   logic take;
   logic op2;
   logic lgc_r;
   logic lgc_nxt;
   assign take = req_valid && req_ready;
   assign op2 = take && req.code[7:2] == 6'h10;
   always_comb
   begin
      lgc_nxt = lgc_r;
      if (done)
         lgc_nxt = 1'b0;
      if (take && req.code[7:1] == 7'h21)
         lgc_nxt = 1'b1;
   end
   always_ff @(posedge clk_sys)
      lgc_r <= rstn ? lgc_nxt : 1'b0;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   // ==========================================================
   // Assertions
   // ==========================================================
   clear_carry_a: assert property (
      take && req.code == 8'h44 |=> done && !carry_flag && !mem_wr_en)
      else $error("carry clear did not finish with carry low");
   first_fetch_a: assert property (
      op2 |=> mem_rd_en && mem_rd_addr == $past(req.addr_a))
      else $error("first operand fetch missing or wrong address");
   op_finish_a: assert property (
      op2 |-> ##[6:12] (done && mem_wr_en))
      else $error("two-operand instruction did not write its result");
   logic_carry_a: assert property (
      lgc_r |-> $stable(carry_flag))
      else $error("carry changed during a logic instruction");
   carry_when_done_a: assert property (
      $changed(carry_flag) |-> done)
      else $error("carry changed outside instruction completion");
   write_done_a: assert property (
      mem_wr_en |-> done && !bad_code)
      else $error("result write not aligned with completion");
   read_pulse_a: assert property (
      mem_rd_en |-> !req_ready ##1 !mem_rd_en)
      else $error("read strobe too long or unit idle while reading");
endmodule : bclalu_core_asserts

bind bclalu_core bclalu_core_asserts #(.DIGITS(DIGITS)) bclalu_core_asserts_inst (
   .clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid), .req(req),
   .req_ready(req_ready), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
   .mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en),
   .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
   .carry_flag(carry_flag), .done(done), .bad_code(bad_code));

/* File: dv/tb.sv */
// Self-checking bench for the BCD and logic ALU core.
// Assumes the core alone; the word memory is modelled here.
`timescale 1ns/1ps
module tb;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic req_valid = 1'b0;
   bclalu_pkg::bclalu_req_t req = '0;
   logic [15:0] mem_rd_data = 16'h0000;
   logic req_ready, mem_rd_en, mem_wr_en, carry_flag, done, bad_code;
   logic [15:0] mem_rd_addr, mem_wr_addr, mem_wr_data;
   logic [15:0] mem [256];
   integer seed = 92944;
   integer errors = 0;
   integer n_tests = 0;
   integer cycles = 0;
   integer cy = 0;
   always #20 clk_sys = ~clk_sys;
   bclalu_core #(.DIGITS(4)) bclalu_core_inst (
      .clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .mem_rd_en(mem_rd_en),
      .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
      .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
      .mem_wr_data(mem_wr_data), .carry_flag(carry_flag), .done(done),
      .bad_code(bad_code));
   // ==========================================================
   // Memory, timeout and helpers
   // ==========================================================
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      mem_rd_data <= mem_rd_en ? mem[mem_rd_addr[7:0]] : ~mem_rd_data;
      // The memory holds BCD words only, so later sums stay defined.
      if (mem_wr_en)
         mem[mem_wr_addr[7:0]] <= bcd_ok(mem_wr_data) ? mem_wr_data :
            mem_wr_data & 16'h7777;
      if (cycles == 20000)
      begin
         errors++;
         wrap_up();
      end
   end
   function automatic integer dec(input logic [15:0] w);
      dec = w[15:12] * 1000 + w[11:8] * 100 + w[7:4] * 10 + w[3:0];
   endfunction : dec
   function automatic logic bcd_ok(input logic [15:0] w);
      bcd_ok = w[15:12] < 4'hA && w[11:8] < 4'hA && w[7:4] < 4'hA &&
         w[3:0] < 4'hA;
   endfunction : bcd_ok
   function automatic logic [15:0] bcd(input integer v);
      bcd = {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction : bcd
   task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_w
   task automatic chk_b(input logic got, input logic exp);
      chk_w({15'h0000, got}, {15'h0000, exp});
   endtask : chk_b
   task automatic wrap_up();
      if (errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up
   // ==========================================================
   // One instruction, driven and checked against the model
   // ==========================================================
   task automatic run_op(input logic [7:0] code, input logic [2:0] ind,
      input logic [15:0] a, input logic [15:0] b, input logic [15:0] d);
      logic [15:0] ra, rb, wa, ew;
      integer s;
      integer k;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req <= '{code, ind[2], ind[1], ind[0], a, b, d};
      @(posedge clk_sys);
      for (k = 0; k < 30 && req_ready !== 1'b1; k++)
         @(posedge clk_sys);
      req_valid <= 1'b0;
      ra = mem[(ind[2] ? mem[a[7:0]] : a) & 16'h00FF];
      rb = mem[(ind[1] ? mem[b[7:0]] : b) & 16'h00FF];
      wa = ind[0] ? mem[d[7:0]] : d;
      ew = 16'h0000;
      s = 0;
      case (code)
         8'h40: s = dec(ra) + dec(rb) + cy;
         8'h41: s = dec(ra) - dec(rb) - cy;
         8'h42: ew = ra & rb;
         8'h43: ew = ra | rb;
         8'h44: cy = 0;
         default: ;
      endcase
      if (code[7:1] == 7'h20)
      begin
         cy = code[0] ? s < 0 : s > 9999;
         ew = bcd(s < 0 ? s + 10000 : s);
      end
      @(negedge clk_sys);
      for (k = 0; k < 30 && done !== 1'b1; k++)
         @(negedge clk_sys);
      chk_b(done, 1'b1);
      chk_b(bad_code, code > 8'h44);
      chk_b(carry_flag, cy[0]);
      chk_b(mem_wr_en, code < 8'h44);
      if (code < 8'h44)
      begin
         chk_w(mem_wr_addr, wa);
         chk_w(mem_wr_data, ew);
      end
   endtask : run_op
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial
   begin
      logic [7:0] codes [6] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h47};
      logic [31:0] r;
      for (int i = 0; i < 256; i++)
      begin
         r = $unsigned($random(seed));
         mem[i] = i < 128 ? bcd(r % 10000) : bcd(r % 80);
      end
      mem[0] = 16'h9999;
      mem[1] = 16'h0001;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      run_op(8'h44, 3'h0, 16'h0000, 16'h0000, 16'h0000);
      run_op(8'h40, 3'h0, 16'h0000, 16'h0001, 16'h0002);
      run_op(8'h41, 3'h0, 16'h0002, 16'h0001, 16'h0003);
      run_op(8'h44, 3'h0, 16'h0000, 16'h0000, 16'h0000);
      run_op(8'h41, 3'h0, 16'h0003, 16'h0001, 16'h0004);
      for (int n = 0; n < 80; n++)
      begin
         r = $unsigned($random(seed));
         run_op(codes[r % 6], 3'(r >> 3), 16'((r >> 6) % 128 + (r & 128)),
            16'((r >> 13) % 128 + ((r >> 1) & 128)),
            16'((r >> 20) % 128 + ((r << 1) & 128)));
      end
      wrap_up();
   end
endmodule : tb
